// >>> core/buck_fault_mode_control.v
`timescale 1ns/10ps
`include "buck_ctl_defs.vh"

module buck_fault_mode_control #(
  parameter CW = 12,
  parameter HICCUP_CYCLES = `HICCUP_CYCLES,
  parameter UV_DELAY_UNIT = `UV_DELAY_UNIT_CYCLES,
  parameter [0:0] FORCED_CONTINUOUS_SEL_DEFAULT = 1'b1
) (
  input wire i_clk, // 200 MHz system clock
  input wire i_resetn, // supply reset, sync, active low
  input wire i_en, // enable pin level
  input wire i_softstart_done, // soft-start ramp complete
  input wire i_uv_detect, // tracking undervolt comparator raw
  input wire i_ls_over_ocl, // low-side current above threshold
  input wire i_zero_cross, // inductor current at zero
  input wire [7:0] i_ton, // high-side on-time in cycles
  input wire [CW-1:0] i_ls_current, // sensed low-side current
  input wire i_reg_wr, // register write strobe
  input wire i_reg_rd, // register read strobe
  input wire [7:0] i_reg_addr, // register offset
  input wire [15:0] i_reg_wdata, // write data
  output reg [15:0] o_reg_rdata, // read data
  output reg o_reg_ack, // one-cycle access acknowledge
  output reg o_hs_on, // high-side driver
  output reg o_ls_on, // low-side driver
  output reg o_converting, // converter running
  output reg o_fault_latched, // drivers latched off
  output reg o_hiccup, // hiccup sleep in progress
  output reg o_mode_forced_continuous_sel // active mode, 1 forced-continuous
);
  localparam ST_OFF = 2'd0; // disabled
  localparam ST_RUN = 2'd1; // switching
  localparam ST_LATCH = 2'd2; // latched off
  localparam ST_HICCUP = 2'd3; // sleeping before restart

  reg [1:0] st; // fault state
  reg [7:0] switch_freq_select; // frequency code
  reg [7:0] undervolt_fault_response; // delay and restart
  reg forced_continuous_sel; // software mode bit
  reg valley_current_clamp_flag; // sticky clamp flag
  reg [8:0] per_cnt; // switching period countdown
  reg [7:0] ton_cnt; // high-side on-time countdown
  reg defer; // high-side start deferred by clamp
  reg [23:0] uv_cnt; // undervolt response delay counter
  reg [23:0] hic_cnt; // hiccup sleep countdown
  reg en_d; // enable pin, last cycle
  wire [CW-1:0] output_current_telemetry; // averaged current
  wire clamp_set; // clamp extends off-time this cycle
  wire start_req; // a new high-side period is due
  wire uv_qual; // qualified undervolt condition
  wire [23:0] uv_limit; // delay in cycles
  wire ocs_clear; // software clear of clamp flag

  // cycles per switching period, full width, cut to the counter in period_of
  localparam integer PER0 = `CLK_FREQ_KHZ / `FSW0_KHZ; // code 00
  localparam integer PER1 = `CLK_FREQ_KHZ / `FSW1_KHZ; // code 01
  localparam integer PER2 = `CLK_FREQ_KHZ / `FSW2_KHZ; // code 02
  localparam integer PER3 = `CLK_FREQ_KHZ / `FSW3_KHZ; // code 03

  // period in cycles for a frequency code, rounded down
  function [8:0] period_of;
    input [1:0] code;
    begin
      case (code)
        2'd0: period_of = PER0[8:0];
        2'd1: period_of = PER1[8:0];
        2'd2: period_of = PER2[8:0];
        default: period_of = PER3[8:0];
      endcase
    end
  endfunction

  ls_current_averager #(.CW(CW), .NW(16)) u_avg (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_ls_on(o_ls_on),
    .i_ls_current(i_ls_current),
    .o_avg(output_current_telemetry)
  );

  assign start_req = (st == ST_RUN) && !o_hs_on && (per_cnt == 9'd0 || defer);
  // the clamp acts in any running phase, soft-start included
  assign clamp_set = start_req && o_ls_on && i_ls_over_ocl;
  // comparator masked during soft-start
  assign uv_qual = (st == ST_RUN) && i_softstart_done && i_uv_detect;
  // code zero still takes one cycle, never instant
  assign uv_limit = 24'd1 + undervolt_fault_response[`UVR_DELAY_MSB:0] * UV_DELAY_UNIT[20:0];
  assign ocs_clear = i_reg_wr && i_reg_addr == `REG_OUTPUT_CURRENT_STATUS && i_reg_wdata[`OCS_CLAMP_BIT];

  // register writes and sticky flag
  always @(posedge i_clk) begin
    if (!i_resetn) begin
      switch_freq_select <= `FREQ_RESET;
      undervolt_fault_response <= `UVR_RESET;
      forced_continuous_sel <= FORCED_CONTINUOUS_SEL_DEFAULT;
      valley_current_clamp_flag <= 1'b0;
    end else begin
      if (i_reg_wr) begin
        case (i_reg_addr)
          `REG_SWITCH_FREQ_SELECT: begin
            if (i_reg_wdata[7:0] <= `FREQ_CODE_MAX) begin
              switch_freq_select <= i_reg_wdata[7:0];
            end
          end
          `REG_UNDERVOLT_FAULT_RESPONSE: begin
            undervolt_fault_response <= i_reg_wdata[7:0];
          end
          `REG_SYSTEM_USER_CONFIG: begin
            // stored at once, takes effect only at next enable
            forced_continuous_sel <= i_reg_wdata[`SUC_FORCED_CONTINUOUS_SEL_BIT];
          end
          default: begin
          end
        endcase
      end
      // set wins over a same-cycle clear
      if (clamp_set) begin
        valley_current_clamp_flag <= 1'b1;
      end else if (ocs_clear) begin
        valley_current_clamp_flag <= 1'b0;
      end
    end
  end

  // register reads, every access acked one cycle later
  always @(posedge i_clk) begin
    if (!i_resetn) begin
      o_reg_rdata <= 16'h0000;
      o_reg_ack <= 1'b0;
    end else begin
      o_reg_ack <= i_reg_wr | i_reg_rd;
      if (i_reg_rd) begin
        case (i_reg_addr)
          `REG_SWITCH_FREQ_SELECT: o_reg_rdata <= {8'h00, switch_freq_select};
          `REG_UNDERVOLT_FAULT_RESPONSE: o_reg_rdata <= {8'h00, undervolt_fault_response};
          `REG_SYSTEM_USER_CONFIG: o_reg_rdata <= {15'h0000, forced_continuous_sel};
          `REG_OUTPUT_CURRENT_STATUS: o_reg_rdata <= {10'h000, valley_current_clamp_flag, 5'h00};
          `REG_OUTPUT_CURRENT_TELEMETRY: o_reg_rdata <= {{(16-CW){1'b0}}, output_current_telemetry};
          default: o_reg_rdata <= 16'h0000; // unmapped reads zero
        endcase
      end
    end
  end

  // fault state machine and response delay
  always @(posedge i_clk) begin
    if (!i_resetn) begin
      st <= ST_OFF;
      uv_cnt <= 24'h000000;
      hic_cnt <= 24'h000000;
      en_d <= 1'b0;
      o_mode_forced_continuous_sel <= 1'b0;
    end else begin
      en_d <= i_en;
      if (!i_en) begin
        st <= ST_OFF;
        uv_cnt <= 24'h000000;
      end else begin
        case (st)
          ST_OFF: begin
            if (!en_d) begin // rising enable
              o_mode_forced_continuous_sel <= forced_continuous_sel;
              st <= ST_RUN;
            end
          end
          ST_RUN: begin
            // clamp has no response of its own; only undervolt or enable low stops us
            if (!uv_qual) begin
              uv_cnt <= 24'h000000;
            end else if (uv_cnt + 24'd1 >= uv_limit) begin
              uv_cnt <= 24'h000000;
              if (undervolt_fault_response[`UVR_RESTART_BIT]) begin
                st <= ST_HICCUP;
                hic_cnt <= HICCUP_CYCLES[23:0] - 24'd1;
              end else begin
                st <= ST_LATCH;
              end
            end else begin
              uv_cnt <= uv_cnt + 24'd1;
            end
          end
          ST_HICCUP: begin
            // no attempt counter: restarts forever
            if (hic_cnt == 24'h000000) begin
              st <= ST_RUN;
            end else begin
              hic_cnt <= hic_cnt - 24'd1;
            end
          end
          ST_LATCH: begin
            st <= ST_LATCH; // only enable low or reset leaves
          end
          default: st <= ST_OFF;
        endcase
      end
    end
  end

  // switching sequencer with valley clamp
  always @(posedge i_clk) begin
    if (!i_resetn) begin
      o_hs_on <= 1'b0;
      o_ls_on <= 1'b0;
      per_cnt <= 9'd0;
      ton_cnt <= 8'h00;
      defer <= 1'b0;
    end else if (st != ST_RUN) begin
      // stopped, latched or sleeping: both drivers off
      o_hs_on <= 1'b0;
      o_ls_on <= 1'b0;
      per_cnt <= 9'd0;
      defer <= 1'b0;
    end else if (start_req) begin
      if (clamp_set) begin
        defer <= 1'b1;
      end else begin
        defer <= 1'b0;
        o_hs_on <= 1'b1;
        o_ls_on <= 1'b0;
        ton_cnt <= (i_ton == 8'h00) ? 8'h00 : i_ton - 8'h01;
        per_cnt <= period_of(switch_freq_select[1:0]) - 9'd1;
      end
    end else begin
      if (per_cnt != 9'd0) begin
        per_cnt <= per_cnt - 9'd1;
      end
      if (o_hs_on) begin
        if (ton_cnt == 8'h00) begin
          o_hs_on <= 1'b0;
          o_ls_on <= 1'b1;
        end else begin
          ton_cnt <= ton_cnt - 8'h01;
        end
      end else if (o_ls_on && !o_mode_forced_continuous_sel && i_zero_cross) begin
        o_ls_on <= 1'b0; // skip mode stops at zero current
      end
    end
  end

  // status outputs registered from state
  always @(posedge i_clk) begin
    if (!i_resetn) begin
      o_converting <= 1'b0;
      o_fault_latched <= 1'b0;
      o_hiccup <= 1'b0;
    end else begin
      o_converting <= (st == ST_RUN);
      o_fault_latched <= (st == ST_LATCH);
      o_hiccup <= (st == ST_HICCUP);
    end
  end
endmodule

// >>> core/ls_current_averager.v
`timescale 1ns/10ps
`include "buck_ctl_defs.vh"

// averages sensed low-side current over each low-side on-period, taking at most its first 65535 samples
module ls_current_averager #(
  parameter CW = 12,
  parameter NW = 16
) (
  input wire i_clk, // system clock
  input wire i_resetn, // sync reset, active low
  input wire i_ls_on, // low-side switch on
  input wire [CW-1:0] i_ls_current, // sensed low-side current
  output reg [CW-1:0] o_avg // last on-period average
);
  reg [CW+NW-1:0] sum; // running sum over the on-period
  reg [NW-1:0] cnt; // samples in the on-period
  reg ls_on_d; // delayed low-side state
  wire [CW+NW-1:0] quot; // sum over count

  // divide by the true sample count, so short periods are not biased
  assign quot = sum / {{CW{1'b0}}, cnt};

  // accumulate while on, publish at the falling edge of on
  always @(posedge i_clk) begin
    if (!i_resetn) begin
      sum <= {(CW+NW){1'b0}};
      cnt <= {NW{1'b0}};
      ls_on_d <= 1'b0;
      o_avg <= {CW{1'b0}};
    end else begin
      ls_on_d <= i_ls_on;
      if (i_ls_on && cnt != {NW{1'b1}}) begin // sum saturates by count limit
        sum <= sum + {{NW{1'b0}}, i_ls_current};
        cnt <= cnt + 1'b1;
      end else if (!i_ls_on && ls_on_d) begin // period ended
        if (cnt != {NW{1'b0}}) begin
          o_avg <= quot[CW-1:0];
        end
        sum <= {(CW+NW){1'b0}};
        cnt <= {NW{1'b0}};
      end
    end
  end
endmodule

// >>> pkg/buck_ctl_defs.vh
`ifndef BUCK_CTL_DEFS_VH
`define BUCK_CTL_DEFS_VH

// register offsets
`define REG_SWITCH_FREQ_SELECT 8'h33
`define REG_UNDERVOLT_FAULT_RESPONSE 8'h45
`define REG_OUTPUT_CURRENT_STATUS 8'h7B
`define REG_OUTPUT_CURRENT_TELEMETRY 8'h8C
`define REG_SYSTEM_USER_CONFIG 8'hA0

// field positions
`define FREQ_CODE_MAX 8'h03
`define UVR_RESTART_BIT 3
`define UVR_DELAY_MSB 2
`define OCS_CLAMP_BIT 5
`define SUC_FORCED_CONTINUOUS_SEL_BIT 0

// reset values
`define FREQ_RESET 8'h00
`define UVR_RESET 8'h00
`define SUC_RESET 8'h01

// timing
`define CLK_FREQ_KHZ 200000
`define FSW0_KHZ 600
`define FSW1_KHZ 800
`define FSW2_KHZ 1000
`define FSW3_KHZ 1200
`define HICCUP_SLEEP_MS 56
`define HICCUP_CYCLES (`HICCUP_SLEEP_MS * `CLK_FREQ_KHZ)
`define UV_DELAY_UNIT_CYCLES 200

`endif

// >>> tb/buck_fault_mode_control_props.sv
`timescale 1ns/10ps
// watches the block's ports; driver and status relations
module buck_fault_mode_control_props #(
  parameter CW = 12
) (
  input wire i_clk, i_resetn, i_en, i_softstart_done, i_uv_detect, // control levels
  input wire i_ls_over_ocl, i_zero_cross, i_reg_wr, i_reg_rd, // sense and strobes
  input wire [7:0] i_ton, i_reg_addr, // on-time, offset
  input wire [CW-1:0] i_ls_current, // current sample
  input wire [15:0] i_reg_wdata, o_reg_rdata, // bus data
  input wire o_reg_ack, o_hs_on, o_ls_on, o_converting, // drivers and run
  input wire o_fault_latched, o_hiccup, o_mode_forced_continuous_sel // status
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // every access, mapped or not, is answered exactly one cycle later
  a_ack_follows_req: assert property ((i_reg_wr || i_reg_rd) |=> o_reg_ack) else $error("ack missing");
  a_ack_needs_req: assert property (o_reg_ack |-> $past(i_reg_wr || i_reg_rd)) else $error("stray ack");
  // mode only moves on an enable edge, never mid-run
  a_mode_run_hold: assert property (o_converting && $past(o_converting) |-> $stable(o_mode_forced_continuous_sel))
    else $error("mode moved in run");
  a_clamp_defers_hs: assert property (o_ls_on && i_ls_over_ocl |=> !o_hs_on) else $error("hs not deferred");
  a_latch_drivers_off: assert property (o_fault_latched |-> !o_hs_on && !o_ls_on) else $error("latch drives");
  a_hiccup_drivers_off: assert property (o_hiccup |-> !o_hs_on && !o_ls_on) else $error("hiccup drives");
  // a stop needs a qualified undervolt two edges back, with soft-start already done
  a_uv_cause_stop: assert property ($rose(o_fault_latched) || $rose(o_hiccup) |->
    $past(i_uv_detect, 2) && $past(i_softstart_done, 2)) else $error("stop without undervolt");
  a_en_low_clears: assert property (!i_en |-> ##2 !o_fault_latched && !o_hiccup && !o_hs_on)
    else $error("enable low kept state");
  c_latch: cover property ($rose(o_fault_latched));
  c_hiccup: cover property ($rose(o_hiccup));
  c_clamp: cover property ((o_ls_on && i_ls_over_ocl) [*8]);
endmodule

bind buck_fault_mode_control buck_fault_mode_control_props #(.CW(CW)) u_props (.*);

// >>> tb/buck_fault_mode_control_tb.sv
`timescale 1ns/10ps
`include "buck_ctl_defs.vh"
module buck_fault_mode_control_tb;
  localparam int HC = 200; // short hiccup keeps the run small
  logic i_clk = 0, i_resetn = 0, i_en = 0, i_softstart_done = 0, i_uv_detect = 0;
  logic i_ls_over_ocl = 0, i_zero_cross = 0, i_reg_wr = 0, i_reg_rd = 0;
  logic [7:0] i_ton = 8'h0A, i_reg_addr = 8'h00;
  logic [11:0] i_ls_current = 12'h5A3; // constant, so the average is known
  logic [15:0] i_reg_wdata = 16'h0000, o_reg_rdata;
  logic [15:0] rdat; // read data taken with the ack
  logic o_reg_ack, o_hs_on, o_ls_on, o_converting, o_fault_latched, o_hiccup, o_mode_forced_continuous_sel;
  int mismatches = 0, samples_checked = 0, n, m;
  int fk [4] = '{`FSW0_KHZ, `FSW1_KHZ, `FSW2_KHZ, `FSW3_KHZ};
  buck_fault_mode_control #(.HICCUP_CYCLES(HC), .UV_DELAY_UNIT(4)) u_dut (.*);
  initial forever #2.5 i_clk = ~i_clk;
  task summarize;
    if (mismatches == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string s, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", s, e, g);
      mismatches++;
    end
  endtask
  // strobe for one edge; ack and read data stand by the next falling edge
  task acc(input logic w, input logic [7:0] a, input logic [15:0] d);
    i_reg_wr = w;
    i_reg_rd = !w;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(negedge i_clk);
    chk("ack", 16'h0001, 16'(o_reg_ack));
    rdat = o_reg_rdata;
    i_reg_wr = 0;
    i_reg_rd = 0;
    // idle edge, so a following call never re-raises a strobe in this step
    @(negedge i_clk);
    chk("ack_end", 16'h0000, 16'(o_reg_ack));
  endtask
  task rd(input logic [7:0] a, input logic [15:0] e);
    acc(0, a, 16'h0000);
    chk("rdata", e, rdat);
  endtask
  // bounded wait on the high-side driver or one status output, counting falling edges
  task wt(input int s, input logic v, output int c);
    c = 0;
    while ((s == 0 ? o_hs_on : s == 1 ? o_fault_latched : o_hiccup) !== v && c < 3000) begin
      @(negedge i_clk);
      c++;
    end
    if (c >= 3000) begin
      $display("Error wait expected %0d seen timeout", s);
      mismatches++;
      summarize();
    end
  endtask
  // rise-to-rise of the high side, skipping the period already running
  task per(input logic [15:0] e);
    wt(0, 0, n);
    wt(0, 1, n);
    wt(0, 0, n);
    wt(0, 1, m);
    chk("period", e, 16'(n + m));
  endtask
  initial begin
    repeat (8) @(negedge i_clk);
    i_resetn = 1;
    @(negedge i_clk);
    rd(`REG_SWITCH_FREQ_SELECT, 16'h0000);
    rd(`REG_UNDERVOLT_FAULT_RESPONSE, 16'h0000);
    rd(`REG_SYSTEM_USER_CONFIG, 16'h0001);
    rd(`REG_OUTPUT_CURRENT_STATUS, 16'h0000);
    acc(1, 8'h10, 16'h00FF);
    rd(8'h10, 16'h0000);
    i_en = 1;
    for (int i = 0; i < 4; i++) begin
      acc(1, `REG_SWITCH_FREQ_SELECT, 16'(i));
      rd(`REG_SWITCH_FREQ_SELECT, 16'(i));
      per(16'(`CLK_FREQ_KHZ / fk[i]));
    end
    acc(1, `REG_SWITCH_FREQ_SELECT, 16'h0004);
    rd(`REG_SWITCH_FREQ_SELECT, 16'h0003);
    per(16'(`CLK_FREQ_KHZ / fk[3]));
    rd(`REG_OUTPUT_CURRENT_TELEMETRY, 16'h05A3);
    // clamp while soft-start still runs
    wt(0, 0, n);
    i_ls_over_ocl = 1;
    repeat (400) @(negedge i_clk);
    chk("hs_defer", 16'h0000, 16'(o_hs_on));
    chk("ls_held", 16'h0001, 16'(o_ls_on));
    rd(`REG_OUTPUT_CURRENT_STATUS, 16'h0020);
    i_ls_over_ocl = 0;
    wt(0, 1, n);
    acc(1, `REG_OUTPUT_CURRENT_STATUS, 16'h0020);
    rd(`REG_OUTPUT_CURRENT_STATUS, 16'h0000);
    acc(1, `REG_SYSTEM_USER_CONFIG, 16'h0000);
    rd(`REG_SYSTEM_USER_CONFIG, 16'h0000);
    chk("mode", 16'h0001, 16'(o_mode_forced_continuous_sel));
    // still forced-continuous: zero crossing must not end the low side
    wt(0, 1, n);
    wt(0, 0, n);
    i_zero_cross = 1;
    repeat (2) @(negedge i_clk);
    chk("forced_continuous_sel_ls", 16'h0001, 16'(o_ls_on));
    i_zero_cross = 0;
    i_en = 0;
    repeat (3) @(negedge i_clk);
    i_en = 1;
    repeat (3) @(negedge i_clk);
    chk("mode", 16'h0000, 16'(o_mode_forced_continuous_sel));
    // auto-skip now: zero crossing ends the low side early
    wt(0, 1, n);
    wt(0, 0, n);
    i_zero_cross = 1;
    repeat (2) @(negedge i_clk);
    chk("skip_ls", 16'h0000, 16'(o_ls_on));
    i_zero_cross = 0;
    i_uv_detect = 1;
    repeat (50) @(negedge i_clk);
    chk("run", 16'h0001, 16'(o_converting));
    i_uv_detect = 0;
    i_softstart_done = 1;
    acc(1, `REG_UNDERVOLT_FAULT_RESPONSE, 16'h0001);
    // four qualified cycles then a gap, one short of the limit of five
    repeat (6) begin
      i_uv_detect = 1;
      repeat (4) @(negedge i_clk);
      i_uv_detect = 0;
      @(negedge i_clk);
    end
    chk("run", 16'h0001, 16'(o_converting));
    i_uv_detect = 1;
    wt(1, 1, n);
    chk("uv_delay", 16'h0006, 16'(n));
    chk("drv", 16'h0000, 16'({o_hs_on, o_ls_on}));
    i_uv_detect = 0;
    repeat (20) @(negedge i_clk);
    chk("latch", 16'h0001, 16'(o_fault_latched));
    i_en = 0;
    @(negedge i_clk);
    i_en = 1;
    repeat (3) @(negedge i_clk);
    chk("latch", 16'h0000, 16'(o_fault_latched));
    chk("run", 16'h0001, 16'(o_converting));
    acc(1, `REG_UNDERVOLT_FAULT_RESPONSE, 16'h0008);
    i_uv_detect = 1;
    for (int k = 0; k < 2; k++) begin
      wt(2, 1, n);
      wt(2, 0, n);
      chk("hiccup", 16'(HC), 16'(n));
    end
    // latch again, then a supply reset in mid-run must release it
    acc(1, `REG_UNDERVOLT_FAULT_RESPONSE, 16'h0000);
    wt(1, 1, n);
    chk("latch", 16'h0001, 16'(o_fault_latched));
    i_uv_detect = 0;
    i_resetn = 0;
    repeat (2) @(negedge i_clk);
    i_resetn = 1;
    repeat (3) @(negedge i_clk);
    chk("latch", 16'h0000, 16'(o_fault_latched));
    chk("run", 16'h0001, 16'(o_converting));
    rd(`REG_UNDERVOLT_FAULT_RESPONSE, 16'h0000);
    summarize();
  end
endmodule
